// File: core/nvmwp_pkg.sv
package nvmwp_pkg;

	// **********************************************************
	// register indices, as seen by the serial protocol engine
	// **********************************************************
	localparam int unsigned ADDR_W            = 8;
	localparam int unsigned DATA_W            = 8;
	localparam logic [7:0]  ADDR_PROTECT_LOW  = 8'h0c;
	localparam logic [7:0]  ADDR_PROTECT_HIGH = 8'h0d;
	localparam logic [7:0]  ADDR_LOCAL_IF_CFG = 8'h0e;
	localparam logic [7:0]  ADDR_SPARE_RSVD   = 8'h0f;

	// **********************************************************
	// field layout and reset values
	// **********************************************************
	localparam int unsigned PULLUP_SEL_BIT    = 5;
	localparam logic [7:0]  PROTECT_RESET     = 8'h00;
	localparam logic [7:0]  LOCAL_IF_RESET    = 8'h00;
	localparam logic [7:0]  SPARE_VALUE       = 8'h00;
	localparam logic [7:0]  PROTECT_WR_MASK   = 8'hff;
	localparam logic [7:0]  PROTECT_STICKY    = 8'hff;
	localparam logic [7:0]  LOCAL_IF_WR_MASK  = 8'h20;
	localparam logic [7:0]  LOCAL_IF_STICKY   = 8'h00;

	// **********************************************************
	// nvm geometry
	// **********************************************************
	localparam int unsigned NVM_BLOCKS        = 16;
	localparam int unsigned NVM_ADDR_W        = 10;
	localparam int unsigned BLOCK_SHIFT       = 6;
	localparam int unsigned BLOCK_IDX_W       = 4;

endpackage

// File: core/nvmwp_stage_reg.sv
`timescale 1ns/100ps

// **********************************************************
// one configuration byte: staged on write, applied on stop
// **********************************************************
module nvmwp_stage_reg #(
	parameter int unsigned WIDTH     = 8,
	parameter logic [7:0]  RESET_VAL = 8'h00,
	parameter logic [7:0]  WR_MASK   = 8'hff,
	parameter logic [7:0]  STICKY    = 8'h00
) (
	input  wire logic             clk,
	input  wire logic             reset_n,
	input  wire logic             wr_stb,
	input  wire logic [WIDTH-1:0] wr_data,
	input  wire logic             commit,
	input  wire logic             unlock,
	output logic      [WIDTH-1:0] value_q
);

	logic [WIDTH-1:0] pend_ff;
	logic [WIDTH-1:0] nxt_pend;
	logic             pend_vld_ff;
	logic             nxt_pend_vld;
	logic [WIDTH-1:0] value_ff;
	logic [WIDTH-1:0] nxt_value;
	logic [WIDTH-1:0] eff_pend;
	logic             eff_vld;
	logic [WIDTH-1:0] merged;
	logic [WIDTH-1:0] wr_mask_w;
	logic [WIDTH-1:0] sticky_w;

	assign wr_mask_w = WR_MASK[WIDTH-1:0];
	assign sticky_w  = STICKY[WIDTH-1:0];

	// a write landing together with the stop is still applied by that stop
	assign eff_pend     = wr_stb ? wr_data : pend_ff;
	assign eff_vld      = wr_stb | pend_vld_ff;
	// sticky bits only accumulate ones unless unlocked
	assign merged       = unlock ? eff_pend : ((value_ff & sticky_w) | eff_pend);
	assign nxt_value    = (commit && eff_vld) ? (merged & wr_mask_w) : value_ff;
	assign nxt_pend     = eff_pend;
	assign nxt_pend_vld = commit ? 1'b0 : eff_vld;
	assign value_q      = value_ff;

	always_ff @(posedge clk)
	begin
		if (!reset_n)
		begin
			pend_ff     <= '0;
			pend_vld_ff <= 1'b0;
			value_ff    <= RESET_VAL[WIDTH-1:0];
		end
		else
		begin
			pend_ff     <= nxt_pend;
			pend_vld_ff <= nxt_pend_vld;
			value_ff    <= nxt_value;
		end
	end

endmodule

// File: core/nvmwp_top.sv
// Functional notes
// - low register bits guard blocks zero to seven
// - high register bits guard blocks eight to fifteen
// - set protection bit clears only in tester mode
// - written settings take effect at bus stop
// - bit five selects external pull-up, default internal
// - host may change pull-up selection after power-up
// - other config bits reserved, read as zero
// - spare register fully reserved, reads zero
// - write to protected block flags error outside tester mode, clearable
`timescale 1ns/100ps

module nvmwp_top (
	input  wire logic                             CLK,
	input  wire logic                             RESET_N,
	input  wire logic                             REG_WR_STB,
	input  wire logic [nvmwp_pkg::ADDR_W-1:0]     REG_WR_ADDR,
	input  wire logic [nvmwp_pkg::DATA_W-1:0]     REG_WR_DATA,
	input  wire logic                             BUS_STOP,
	input  wire logic [nvmwp_pkg::ADDR_W-1:0]     REG_RD_ADDR,
	output logic      [nvmwp_pkg::DATA_W-1:0]     REG_RD_DATA,
	output logic                                  REG_RD_HIT,
	input  wire logic                             TESTER_MODE,
	input  wire logic                             NVM_WR_REQ,
	input  wire logic [nvmwp_pkg::NVM_ADDR_W-1:0] NVM_WR_ADDR,
	output logic                                  NVM_WR_BLOCKED,
	output logic                                  NVM_WR_GRANT,
	output logic                                  PROT_ERR,
	input  wire logic                             PROT_ERR_CLR,
	output logic      [nvmwp_pkg::NVM_BLOCKS-1:0] PROTECT_MAP,
	output logic                                  LOCAL_PULLUP_EXT
);

	// **********************************************************
	// offline tester mode strap synchroniser
	// **********************************************************
	logic tester_s1_ff;
	logic tester_s2_ff;
	logic tester_s3_ff;
	logic tester_ff;
	logic nxt_tester;

	// change accepted only once stages two and three agree
	assign nxt_tester = (tester_s2_ff == tester_s3_ff) ? tester_s3_ff : tester_ff;

	always_ff @(posedge CLK)
	begin
		if (!RESET_N)
		begin
			tester_s1_ff <= 1'b0;
			tester_s2_ff <= 1'b0;
			tester_s3_ff <= 1'b0;
			tester_ff    <= 1'b0;
		end
		else
		begin
			tester_s1_ff <= TESTER_MODE;
			tester_s2_ff <= tester_s1_ff;
			tester_s3_ff <= tester_s2_ff;
			tester_ff    <= nxt_tester;
		end
	end

	// **********************************************************
	// write decode and staged registers
	// **********************************************************
	localparam int unsigned NUM_REGS = 3;

	function automatic logic addr_is(input logic [7:0] a, input logic [7:0] ref_a);
		addr_is = (a == ref_a);
	endfunction

	logic [7:0]          reg_addr [NUM_REGS];
	logic [7:0]          reg_val  [NUM_REGS];
	logic [NUM_REGS-1:0] reg_wr;

	assign reg_addr[0] = nvmwp_pkg::ADDR_PROTECT_LOW;
	assign reg_addr[1] = nvmwp_pkg::ADDR_PROTECT_HIGH;
	assign reg_addr[2] = nvmwp_pkg::ADDR_LOCAL_IF_CFG;

	genvar gi;
	generate
		for (gi = 0; gi < NUM_REGS; gi++)
		begin : g_regs
			localparam logic [7:0] RST = (gi == 2) ? nvmwp_pkg::LOCAL_IF_RESET   : nvmwp_pkg::PROTECT_RESET;
			localparam logic [7:0] MSK = (gi == 2) ? nvmwp_pkg::LOCAL_IF_WR_MASK : nvmwp_pkg::PROTECT_WR_MASK;
			localparam logic [7:0] STK = (gi == 2) ? nvmwp_pkg::LOCAL_IF_STICKY  : nvmwp_pkg::PROTECT_STICKY;

			// spare register has no storage at all, so writes to it vanish
			assign reg_wr[gi] = REG_WR_STB && addr_is(REG_WR_ADDR, reg_addr[gi]);

			nvmwp_stage_reg #(
				.WIDTH     (8),
				.RESET_VAL (RST),
				.WR_MASK   (MSK),
				.STICKY    (STK)
			) u_stage (
				.clk     (CLK),
				.reset_n (RESET_N),
				.wr_stb  (reg_wr[gi]),
				.wr_data (REG_WR_DATA),
				.commit  (BUS_STOP),
				.unlock  (tester_ff),
				.value_q (reg_val[gi])
			);
		end
	endgenerate

	logic [nvmwp_pkg::NVM_BLOCKS-1:0] prot_map;
	logic [7:0]                       cfg_val;

	assign prot_map         = {reg_val[1], reg_val[0]};
	assign cfg_val          = reg_val[2];
	assign PROTECT_MAP      = prot_map;
	assign LOCAL_PULLUP_EXT = cfg_val[nvmwp_pkg::PULLUP_SEL_BIT];

	// **********************************************************
	// register read port, one cycle latency
	// **********************************************************
	logic [7:0] rd_data_ff;
	logic [7:0] nxt_rd_data;
	logic       rd_hit_ff;
	logic       nxt_rd_hit;
	logic       rd_low;
	logic       rd_high;
	logic       rd_cfg;
	logic       rd_spare;

	assign rd_low      = addr_is(REG_RD_ADDR, nvmwp_pkg::ADDR_PROTECT_LOW);
	assign rd_high     = addr_is(REG_RD_ADDR, nvmwp_pkg::ADDR_PROTECT_HIGH);
	assign rd_cfg      = addr_is(REG_RD_ADDR, nvmwp_pkg::ADDR_LOCAL_IF_CFG);
	assign rd_spare    = addr_is(REG_RD_ADDR, nvmwp_pkg::ADDR_SPARE_RSVD);
	assign nxt_rd_hit  = rd_low | rd_high | rd_cfg | rd_spare;
	assign nxt_rd_data = rd_low   ? reg_val[0] :
	                     rd_high  ? reg_val[1] :
	                     rd_cfg   ? (cfg_val & nvmwp_pkg::LOCAL_IF_WR_MASK) :
	                     rd_spare ? nvmwp_pkg::SPARE_VALUE : 8'h00;

	always_ff @(posedge CLK)
	begin
		if (!RESET_N)
		begin
			rd_data_ff <= 8'h00;
			rd_hit_ff  <= 1'b0;
		end
		else
		begin
			rd_data_ff <= nxt_rd_data;
			rd_hit_ff  <= nxt_rd_hit;
		end
	end

	assign REG_RD_DATA = rd_data_ff;
	assign REG_RD_HIT  = rd_hit_ff;

	// **********************************************************
	// nvm write guard and error flag
	// **********************************************************
	logic [nvmwp_pkg::BLOCK_IDX_W-1:0] wr_block;
	logic                              blocked;
	logic                              err_ff;
	logic                              nxt_err;

	assign wr_block       = NVM_WR_ADDR[nvmwp_pkg::NVM_ADDR_W-1:nvmwp_pkg::BLOCK_SHIFT];
	// offline tester overrides protection for the array as well
	assign blocked        = NVM_WR_REQ && prot_map[wr_block] && !tester_ff;
	assign NVM_WR_BLOCKED = blocked;
	assign NVM_WR_GRANT   = NVM_WR_REQ && !blocked;
	// a new violation in the clear cycle keeps the flag set
	assign nxt_err        = blocked | (err_ff & !PROT_ERR_CLR);

	always_ff @(posedge CLK)
	begin
		if (!RESET_N)
			err_ff <= 1'b0;
		else
			err_ff <= nxt_err;
	end

	assign PROT_ERR = err_ff;

	// **********************************************************
	// assertions
	// **********************************************************
	property p_prot_sticky;
		@(posedge CLK) disable iff (!RESET_N)
		!tester_ff |=> ((prot_map & $past(prot_map)) == $past(prot_map));
	endproperty
	a_prot_sticky: assert property (p_prot_sticky) else $error("protection bit cleared outside tester mode");

	property p_prot_on_stop;
		@(posedge CLK) disable iff (!RESET_N)
		(prot_map != $past(prot_map)) |-> $past(BUS_STOP);
	endproperty
	a_prot_on_stop: assert property (p_prot_on_stop) else $error("protection changed without stop");

	property p_cfg_on_stop;
		@(posedge CLK) disable iff (!RESET_N)
		$changed(LOCAL_PULLUP_EXT) |-> $past(BUS_STOP);
	endproperty
	a_cfg_on_stop: assert property (p_cfg_on_stop) else $error("pull-up select changed without stop");

	property p_set_applies;
		@(posedge CLK) disable iff (!RESET_N)
		(REG_WR_STB && REG_WR_ADDR == nvmwp_pkg::ADDR_PROTECT_LOW && BUS_STOP)
		|=> ((prot_map[7:0] & $past(REG_WR_DATA)) == $past(REG_WR_DATA));
	endproperty
	a_set_applies: assert property (p_set_applies) else $error("written one not applied at stop");

	property p_cfg_reserved;
		@(posedge CLK) disable iff (!RESET_N)
		(cfg_val & ~nvmwp_pkg::LOCAL_IF_WR_MASK) == 8'h00;
	endproperty
	a_cfg_reserved: assert property (p_cfg_reserved) else $error("reserved config bit set");

	property p_spare_zero;
		@(posedge CLK) disable iff (!RESET_N)
		(REG_RD_ADDR == nvmwp_pkg::ADDR_SPARE_RSVD) |=> (REG_RD_DATA == 8'h00) && REG_RD_HIT;
	endproperty
	a_spare_zero: assert property (p_spare_zero) else $error("spare register read not zero");

	property p_read_high;
		@(posedge CLK) disable iff (!RESET_N)
		(REG_RD_ADDR == nvmwp_pkg::ADDR_PROTECT_HIGH) |=> (REG_RD_DATA == $past(prot_map[15:8]));
	endproperty
	a_read_high: assert property (p_read_high) else $error("high protection read mismatch");

	property p_block_guard;
		@(posedge CLK) disable iff (!RESET_N)
		(NVM_WR_REQ && !tester_ff) |-> (NVM_WR_BLOCKED == prot_map[NVM_WR_ADDR[9:6]]) ##1 (PROT_ERR || !$past(blocked));
	endproperty
	a_block_guard: assert property (p_block_guard) else $error("protected block write not blocked and flagged");

	property p_err_hold;
		@(posedge CLK) disable iff (!RESET_N)
		(PROT_ERR && !PROT_ERR_CLR) |=> PROT_ERR;
	endproperty
	a_err_hold: assert property (p_err_hold) else $error("error flag dropped without clear");

	property p_read_low;
		@(posedge CLK) disable iff (!RESET_N)
		(REG_RD_ADDR == nvmwp_pkg::ADDR_PROTECT_LOW) |=> (REG_RD_DATA == $past(prot_map[7:0]));
	endproperty
	a_read_low: assert property (p_read_low) else $error("low protection read mismatch");

	property p_read_cfg;
		@(posedge CLK) disable iff (!RESET_N)
		(REG_RD_ADDR == nvmwp_pkg::ADDR_LOCAL_IF_CFG)
		|=> (REG_RD_DATA == (8'($past(LOCAL_PULLUP_EXT)) << nvmwp_pkg::PULLUP_SEL_BIT));
	endproperty
	a_read_cfg: assert property (p_read_cfg) else $error("config read mismatch");

	property p_cfg_hit;
		@(posedge CLK) disable iff (!RESET_N)
		(REG_RD_ADDR == nvmwp_pkg::ADDR_LOCAL_IF_CFG) |=> REG_RD_HIT;
	endproperty
	a_cfg_hit: assert property (p_cfg_hit) else $error("config read not hit");

	property p_read_miss;
		@(posedge CLK) disable iff (!RESET_N)
		(REG_RD_ADDR < nvmwp_pkg::ADDR_PROTECT_LOW || REG_RD_ADDR > nvmwp_pkg::ADDR_SPARE_RSVD)
		|=> (!REG_RD_HIT && REG_RD_DATA == 8'h00);
	endproperty
	a_read_miss: assert property (p_read_miss) else $error("unmapped read not empty");

	property p_err_set;
		@(posedge CLK) disable iff (!RESET_N)
		(NVM_WR_REQ && !tester_ff && prot_map[wr_block]) |=> PROT_ERR;
	endproperty
	a_err_set: assert property (p_err_set) else $error("blocked write left error low");

	property p_err_clear;
		@(posedge CLK) disable iff (!RESET_N)
		(PROT_ERR_CLR && !NVM_WR_BLOCKED) |=> !PROT_ERR;
	endproperty
	a_err_clear: assert property (p_err_clear) else $error("error flag not cleared");

	property p_err_quiet;
		@(posedge CLK) disable iff (!RESET_N)
		(!PROT_ERR && !NVM_WR_BLOCKED) |=> !PROT_ERR;
	endproperty
	a_err_quiet: assert property (p_err_quiet) else $error("error flag rose without block");

	property p_tester_open;
		@(posedge CLK) disable iff (!RESET_N)
		tester_ff |-> !NVM_WR_BLOCKED;
	endproperty
	a_tester_open: assert property (p_tester_open) else $error("write blocked in tester mode");

	property p_guard_idle;
		@(posedge CLK) disable iff (!RESET_N)
		!NVM_WR_REQ |-> (!NVM_WR_GRANT && !NVM_WR_BLOCKED);
	endproperty
	a_guard_idle: assert property (p_guard_idle) else $error("guard answer without request");

	property p_guard_excl;
		@(posedge CLK) disable iff (!RESET_N)
		NVM_WR_REQ |-> (NVM_WR_GRANT != NVM_WR_BLOCKED);
	endproperty
	a_guard_excl: assert property (p_guard_excl) else $error("grant and block not exclusive");

	property p_high_set_applies;
		@(posedge CLK) disable iff (!RESET_N)
		(REG_WR_STB && REG_WR_ADDR == nvmwp_pkg::ADDR_PROTECT_HIGH && BUS_STOP)
		|=> ((prot_map[15:8] & $past(REG_WR_DATA)) == $past(REG_WR_DATA));
	endproperty
	a_high_set_applies: assert property (p_high_set_applies) else $error("high one not applied");

endmodule

// File: tb/nvmwp_host_model.sv
`timescale 1ns/100ps

// ******************************
// host side of the register path
// ******************************
module nvmwp_host_model (
	input  wire logic                         clk,
	output logic                              wr_stb,
	output logic [nvmwp_pkg::ADDR_W-1:0]      wr_addr,
	output logic [nvmwp_pkg::DATA_W-1:0]      wr_data,
	output logic                              bus_stop
);
	initial
	begin
		wr_stb = 1'b0;
		wr_addr = 8'h00;
		wr_data = 8'h00;
		bus_stop = 1'b0;
	end

	// pull-up choice may be rewritten at any time after power-up
	task automatic wr(input logic [7:0] a, input logic [7:0] d, input bit stop);
		@(posedge clk);
		#1;
		wr_stb = 1'b1;
		wr_addr = a;
		wr_data = d;
		@(posedge clk);
		#1;
		wr_stb = 1'b0;
		// released bus must not keep showing the byte
		wr_data = ~d;
		if (stop)
			send_stop();
	endtask

	// write landing in the stop cycle is applied by that same stop
	task automatic wr_at_stop(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		#1;
		wr_stb = 1'b1;
		wr_addr = a;
		wr_data = d;
		bus_stop = 1'b1;
		@(posedge clk);
		#1;
		wr_stb = 1'b0;
		wr_data = ~d;
		bus_stop = 1'b0;
	endtask

	task automatic send_stop();
		bus_stop = 1'b1;
		@(posedge clk);
		#1;
		bus_stop = 1'b0;
	endtask
endmodule

// File: tb/nvmwp_tb_top.sv
`timescale 1ns/100ps

module nvmwp_tb_top;
	typedef struct {logic [7:0] a; logic [7:0] d; logic t; logic [7:0] e;} nvmwp_row_s;
	logic        clk;
	logic        rst_n;
	logic        stb;
	logic [7:0]  wa;
	logic [7:0]  wd;
	logic        stop;
	logic [7:0]  ra;
	logic [7:0]  rd;
	logic        hit;
	logic        tester;
	logic        req;
	logic [9:0]  na;
	logic        blk;
	logic        gnt;
	logic        err;
	logic        clr;
	logic [15:0] map;
	logic        pu;
	logic [15:0] exp_map;
	int          err_total;
	int          n_checks;
	nvmwp_row_s  rows [8];

	nvmwp_top i_nvmwp_top (.CLK(clk), .RESET_N(rst_n), .REG_WR_STB(stb), .REG_WR_ADDR(wa), .REG_WR_DATA(wd),
		.BUS_STOP(stop), .REG_RD_ADDR(ra), .REG_RD_DATA(rd), .REG_RD_HIT(hit), .TESTER_MODE(tester),
		.NVM_WR_REQ(req), .NVM_WR_ADDR(na), .NVM_WR_BLOCKED(blk), .NVM_WR_GRANT(gnt), .PROT_ERR(err),
		.PROT_ERR_CLR(clr), .PROTECT_MAP(map), .LOCAL_PULLUP_EXT(pu));
	nvmwp_host_model i_nvmwp_host_model (.clk(clk), .wr_stb(stb), .wr_addr(wa), .wr_data(wd), .bus_stop(stop));

	initial
	begin
		clk = 1'b0;
		forever
			#4 clk = ~clk;
	end

	task automatic chk(input logic [15:0] g, input logic [15:0] e);
		n_checks++;
		if (g !== e)
		begin
			err_total++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask

	task automatic rdc(input logic [7:0] a, input logic [7:0] e, input logic h);
		@(posedge clk);
		#1;
		ra = a;
		@(posedge clk);
		#1;
		chk(rd, e);
		chk(hit, h);
	endtask

	task automatic nvm(input logic [9:0] a, input logic b);
		@(posedge clk);
		#1;
		req = 1'b1;
		na = a;
		#1;
		chk(blk, b);
		chk(gnt, !b);
		@(posedge clk);
		#1;
		req = 1'b0;
	endtask

	task automatic set_tester(input logic t);
		@(posedge clk);
		#1;
		tester = t;
		// mode pin passes a synchroniser first
		repeat (6) @(posedge clk);
	endtask

	task automatic close_out();
		$display("checks=%0d errors=%0d", n_checks, err_total);
		if (err_total == 0 && n_checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	initial
	begin
		#20000;
		err_total++;
		close_out();
	end

	initial
	begin
		rows = '{'{8'h0c, 8'h05, 1'b0, 8'h05}, '{8'h0c, 8'h00, 1'b0, 8'h05}, '{8'h0c, 8'ha0, 1'b0, 8'ha5},
			'{8'h0d, 8'h81, 1'b0, 8'h81}, '{8'h0e, 8'h20, 1'b0, 8'h20}, '{8'h0e, 8'h00, 1'b0, 8'h00},
			'{8'h0c, 8'h01, 1'b1, 8'h01}, '{8'h0d, 8'h80, 1'b1, 8'h80}};
		err_total = 0;
		n_checks = 0;
		rst_n = 1'b0;
		ra = 8'h00;
		tester = 1'b0;
		req = 1'b0;
		na = 10'h000;
		clr = 1'b0;
		exp_map = 16'h0000;
		repeat (16) @(posedge clk);
		#1;
		rst_n = 1'b1;
		chk(map, 16'h0000);
		chk({pu, err}, 16'h0000);
		rdc(8'h0e, 8'h00, 1'b1);
		for (int i = 0; i < 8; i++)
		begin
			set_tester(rows[i].t);
			i_nvmwp_host_model.wr(rows[i].a, rows[i].d, 1'b1);
			if (rows[i].a == 8'h0c)
				exp_map[7:0] = rows[i].e;
			if (rows[i].a == 8'h0d)
				exp_map[15:8] = rows[i].e;
			rdc(rows[i].a, rows[i].e, 1'b1);
			chk(map, exp_map);
			chk(pu, (rows[i].a == 8'h0e) ? rows[i].e[5] : 1'b0);
		end
		set_tester(1'b0);
		i_nvmwp_host_model.wr(8'h0c, 8'h10, 1'b0);
		repeat (3) @(posedge clk);
		#1;
		chk(map, 16'h8001);
		i_nvmwp_host_model.send_stop();
		chk(map, 16'h8011);
		i_nvmwp_host_model.wr_at_stop(8'h0c, 8'h02);
		chk(map, 16'h8013);
		i_nvmwp_host_model.wr_at_stop(8'h0d, 8'h01);
		chk(map, 16'h8113);
		nvm(10'h100, 1'b1);
		chk(err, 1'b1);
		nvm(10'h3c0, 1'b1);
		nvm(10'h140, 1'b0);
		// new violation in the clear cycle must keep the flag
		@(posedge clk);
		#1;
		clr = 1'b1;
		req = 1'b1;
		na = 10'h040;
		@(posedge clk);
		#1;
		clr = 1'b0;
		req = 1'b0;
		chk(err, 1'b1);
		clr = 1'b1;
		@(posedge clk);
		#1;
		clr = 1'b0;
		chk(err, 1'b0);
		set_tester(1'b1);
		nvm(10'h040, 1'b0);
		set_tester(1'b0);
		chk(err, 1'b0);
		i_nvmwp_host_model.wr(8'h0e, 8'hff, 1'b1);
		rdc(8'h0e, 8'h20, 1'b1);
		chk(pu, 1'b1);
		// reset in mid-run must drop applied settings
		rst_n = 1'b0;
		repeat (3) @(posedge clk);
		#1;
		rst_n = 1'b1;
		chk(map, 16'h0000);
		chk({pu, err}, 16'h0000);
		rdc(8'h0f, 8'h00, 1'b1);
		rdc(8'h10, 8'h00, 1'b0);
		close_out();
	end
endmodule
